// ==== sepr_defs.vh ====
`ifndef SEPR_DEFS_VH
`define SEPR_DEFS_VH

// ==========================================================
// array and counter sizes
`define SEPR_ADDR_W      14
`define SEPR_DATA_W      8
`define SEPR_MEM_DEPTH   16384
`define SEPR_PAGE_W      6
`define SEPR_HI_W        6

// ==========================================================
// slave address byte fields
`define SEPR_TYPE_MSB    7
`define SEPR_TYPE_LSB    4
`define SEPR_SEL_MSB     3
`define SEPR_SEL_LSB     2
`define SEPR_RW_BIT      0

// ==========================================================
// byte index within a frame
`define SEPR_IDX_DEV     2'h0
`define SEPR_IDX_AHI     2'h1
`define SEPR_IDX_ALO     2'h2
`define SEPR_IDX_DATA    2'h3

// ==========================================================
// timing
`define SEPR_TWR_MS      5
`define SEPR_CLK_KHZ     100000
`define SEPR_TWR_CYC     (`SEPR_TWR_MS * `SEPR_CLK_KHZ)
`define SEPR_CNT_W       20

// ==========================================================
// reset values and idle transmit byte
`define SEPR_ADDR_RST    14'h0000
`define SEPR_BYTE_RST    8'h00
`define SEPR_IDLE_BYTE   8'hFF

`endif

// ==== sepr_buf2.v ====
`timescale 1ns/10ps
`include "sepr_defs.vh"

// two-entry buffer between array read and transmit shifter
module sepr_buf2
#(
	parameter WIDTH = `SEPR_DATA_W
)
(
	input  wire             sys_clk_i,
	input  wire             resetn_i,
	input  wire             flush_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);

	reg [WIDTH-1:0] slot_reg [0:1];
	reg             wr_ptr_reg;
	reg             rd_ptr_reg;
	reg [1:0]       count_reg;
	wire            push;
	wire            pop;

	assign in_ready_o  = (count_reg != 2'h2);
	assign out_valid_o = (count_reg != 2'h0);
	assign out_data_o  = slot_reg[rd_ptr_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge sys_clk_i)
	begin
		if (push)
			slot_reg[wr_ptr_reg] <= in_data_i;
	end

	always @(posedge sys_clk_i)
	begin
		if (!resetn_i || flush_i)
		begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			if (push && !pop)
				count_reg <= count_reg + 2'h1;
			else if (pop && !push)
				count_reg <= count_reg - 2'h1;
		end
	end

endmodule

// ==== sepr_eeprom.v ====
`timescale 1ns/10ps
`include "sepr_defs.vh"

// How it works
// - no acknowledge while programming runs
// - acknowledge address again once programming ends
// - direction bit one means read
// - counter points past last accessed byte
// - current read acks then sends counter byte
// - read past top location returns location 0
// - ack word address, ack read, send byte
// - each master ack fetches next byte
// - counter increments after every sent byte
// - counter wraps from 16383 to 0 on reads, and within the 64-byte page on writes
// - match type code and strap bits
// - busy device ignores bus apart from nack
module sepr_eeprom
#(
	parameter [3:0]  DEV_TYPE  = 4'h5,
	parameter        WR_CYCLES = `SEPR_TWR_CYC
)
(
	input  wire       sys_clk_i,
	input  wire       resetn_i,
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       sda_o,
	output wire       sda_oe_o,
	input  wire [1:0] chip_select_straps_i,
	output wire       write_busy_o
);
	// DEV_TYPE default is an arbitrary value

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_RX    = 3'h1;
	localparam [2:0] ST_RXACK = 3'h2;
	localparam [2:0] ST_TX    = 3'h3;
	localparam [2:0] ST_TXACK = 3'h4;

	// ==========================================================
	// pin synchronisers
	reg  [3:0]                s1_reg;
	reg  [3:0]                s2_reg;
	reg                       scl_d_reg;
	reg                       sda_d_reg;
	wire                      scl_s;
	wire                      sda_s;
	wire [1:0]                straps_s;
	wire                      scl_rise;
	wire                      scl_fall;
	wire                      start_det;
	wire                      stop_det;

	always @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			s1_reg    <= 4'h3;
			s2_reg    <= 4'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			s1_reg    <= {chip_select_straps_i, sda_i, scl_i};
			s2_reg    <= s1_reg;
			scl_d_reg <= s2_reg[0];
			sda_d_reg <= s2_reg[1];
		end
	end

	assign scl_s     = s2_reg[0];
	assign sda_s     = s2_reg[1];
	assign straps_s  = s2_reg[3:2];
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
	assign stop_det  = scl_s & scl_d_reg & sda_s & ~sda_d_reg;

	// ==========================================================
	// state and datapath registers
	reg  [2:0]                state_reg;
	reg  [3:0]                bit_cnt_reg;
	reg  [1:0]                idx_reg;
	reg  [7:0]                rx_sh_reg;
	reg  [7:0]                tx_sh_reg;
	reg                       ack_reg;
	reg                       rd_mode_reg;
	reg                       rd_active_reg;
	reg                       wr_dirty_reg;
	reg                       sda_oe_reg;
	reg                       sda_o_reg;
	reg                       busy_reg;
	reg  [`SEPR_CNT_W-1:0]    busy_cnt_reg;
	reg  [`SEPR_HI_W-1:0]     addr_hi_reg;
	reg  [`SEPR_ADDR_W-1:0]   addr_reg;
	reg  [`SEPR_ADDR_W-1:0]   pf_reg;
	reg  [`SEPR_DATA_W-1:0]   mem [0:`SEPR_MEM_DEPTH-1];

	wire                      byte_done;
	wire [7:0]                rx_byte;
	wire                      dev_match;
	wire                      mem_we;
	wire                      buf_in_ready;
	wire                      buf_out_valid;
	wire [7:0]                buf_out_data;
	wire                      buf_pop;
	wire                      buf_flush;
	wire [7:0]                tx_byte;

	function addr_hit;
		input [7:0] b;
		input [1:0] sel;
		input [3:0] dtype;
		begin
			addr_hit = (b[`SEPR_TYPE_MSB:`SEPR_TYPE_LSB] == dtype) &&
				(b[`SEPR_SEL_MSB:`SEPR_SEL_LSB] == sel);
		end
	endfunction

	assign byte_done = (state_reg == ST_RX) && scl_rise && (bit_cnt_reg == 4'h7);
	assign rx_byte   = {rx_sh_reg[6:0], sda_s};
	assign dev_match = addr_hit(rx_byte, straps_s, DEV_TYPE);
	assign mem_we    = byte_done && !rd_mode_reg && (idx_reg == `SEPR_IDX_DATA);
	assign buf_pop   = (state_reg == ST_RXACK) ? (scl_fall && ack_reg && rd_mode_reg) :
		((state_reg == ST_TXACK) && scl_fall && !start_det && !stop_det);
	assign buf_flush = start_det || stop_det ||
		((state_reg == ST_TXACK) && scl_rise && sda_s);
	assign tx_byte   = buf_out_valid ? buf_out_data : `SEPR_IDLE_BYTE;

	// ==========================================================
	// array and read-ahead buffer
	always @(posedge sys_clk_i)
	begin
		if (mem_we)
			mem[addr_reg] <= rx_byte;
	end

	sepr_buf2
	#(
		.WIDTH (`SEPR_DATA_W)
	)
	u_buf
	(
		.sys_clk_i   (sys_clk_i),
		.resetn_i    (resetn_i),
		.flush_i     (buf_flush),
		.in_valid_i  (rd_active_reg && !buf_flush),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (mem[pf_reg]),
		.out_valid_o (buf_out_valid),
		.out_ready_i (buf_pop),
		.out_data_o  (buf_out_data)
	);

	// ==========================================================
	// programming cycle timer
	always @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			busy_reg     <= 1'b0;
			busy_cnt_reg <= {`SEPR_CNT_W{1'b0}};
		end
		// only a stop after data starts programming
		else if (stop_det && wr_dirty_reg && !busy_reg)
		begin
			busy_reg     <= 1'b1;
			busy_cnt_reg <= {`SEPR_CNT_W{1'b0}};
		end
		// busy ends after write cycle time
		else if (busy_reg)
		begin
			if (busy_cnt_reg == WR_CYCLES[`SEPR_CNT_W-1:0] - 1'b1)
				busy_reg <= 1'b0;
			busy_cnt_reg <= busy_cnt_reg + 1'b1;
		end
	end

	// ==========================================================
	// read-ahead pointer
	always @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			rd_active_reg <= 1'b0;
			pf_reg        <= `SEPR_ADDR_RST;
		end
		else if (buf_flush)
			rd_active_reg <= 1'b0;
		else if (byte_done && idx_reg == `SEPR_IDX_DEV && dev_match && !busy_reg &&
			rx_byte[`SEPR_RW_BIT])
		begin
			rd_active_reg <= 1'b1;
			pf_reg        <= addr_reg;
		end
		else if (rd_active_reg && buf_in_ready)
			pf_reg <= pf_reg + 1'b1;
	end

	// ==========================================================
	// bus protocol engine
	always @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			idx_reg      <= `SEPR_IDX_DEV;
			rx_sh_reg    <= `SEPR_BYTE_RST;
			tx_sh_reg    <= `SEPR_BYTE_RST;
			ack_reg      <= 1'b0;
			rd_mode_reg  <= 1'b0;
			wr_dirty_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
			sda_o_reg    <= 1'b0;
			addr_hi_reg  <= {`SEPR_HI_W{1'b0}};
			addr_reg     <= `SEPR_ADDR_RST;
		end
		else if (start_det)
		begin
			state_reg    <= ST_RX;
			bit_cnt_reg  <= 4'h0;
			idx_reg      <= `SEPR_IDX_DEV;
			sda_oe_reg   <= 1'b0;
			rd_mode_reg  <= 1'b0;
			wr_dirty_reg <= 1'b0;
		end
		else if (stop_det)
		begin
			state_reg    <= ST_IDLE;
			sda_oe_reg   <= 1'b0;
			wr_dirty_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_RX:
				begin
					if (scl_rise)
					begin
						rx_sh_reg   <= rx_byte;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					if (byte_done)
					begin
						if (idx_reg != `SEPR_IDX_DATA)
							idx_reg <= idx_reg + 2'h1;
						case (idx_reg)
							`SEPR_IDX_DEV:
							begin
								ack_reg     <= dev_match && !busy_reg;
								rd_mode_reg <= rx_byte[`SEPR_RW_BIT];
							end
							`SEPR_IDX_AHI:
							begin
								ack_reg     <= 1'b1;
								addr_hi_reg <= rx_byte[`SEPR_HI_W-1:0];
							end
							`SEPR_IDX_ALO:
							begin
								ack_reg  <= 1'b1;
								addr_reg <= {addr_hi_reg, rx_byte};
							end
							default:
							begin
								ack_reg      <= 1'b1;
								wr_dirty_reg <= 1'b1;
								addr_reg     <= {addr_reg[`SEPR_ADDR_W-1:`SEPR_PAGE_W],
									addr_reg[`SEPR_PAGE_W-1:0] + 1'b1};
							end
						endcase
					end
					else if (scl_fall && bit_cnt_reg == 4'h8)
					begin
						state_reg   <= ST_RXACK;
						bit_cnt_reg <= 4'h0;
						sda_oe_reg  <= ack_reg;
					end
				end
				ST_RXACK:
				begin
					if (scl_fall)
					begin
						if (!ack_reg)
						begin
							state_reg  <= ST_IDLE;
							sda_oe_reg <= 1'b0;
						end
						else if (rd_mode_reg)
						begin
							state_reg  <= ST_TX;
							tx_sh_reg  <= tx_byte;
							sda_oe_reg <= ~tx_byte[7];
							addr_reg   <= addr_reg + 1'b1;
						end
						else
						begin
							state_reg  <= ST_RX;
							sda_oe_reg <= 1'b0;
						end
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_reg == 4'h7)
						begin
							state_reg   <= ST_TXACK;
							bit_cnt_reg <= 4'h0;
							sda_oe_reg  <= 1'b0;
						end
						else
						begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
							sda_oe_reg  <= ~tx_sh_reg[6];
						end
					end
				end
				ST_TXACK:
				begin
					if (scl_rise && sda_s)
						state_reg <= ST_IDLE;
					else if (scl_fall)
					begin
						state_reg  <= ST_TX;
						tx_sh_reg  <= tx_byte;
						sda_oe_reg <= ~tx_byte[7];
						addr_reg   <= addr_reg + 1'b1;
					end
				end
				default:
				begin
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	assign sda_o        = sda_o_reg;
	assign sda_oe_o     = sda_oe_reg;
	assign write_busy_o = busy_reg;

endmodule

// ==== sepr_eeprom_chk.sv ====
`timescale 1ns/10ps
// ==========================================
// slave pin checks
module sepr_eeprom_chk
#(
	parameter WR_CYCLES = 200
)
(
	input wire       sys_clk_i,
	input wire       resetn_i,
	input wire       scl_i,
	input wire       sda_i,
	input wire       sda_o,
	input wire       sda_oe_o,
	input wire [1:0] chip_select_straps_i,
	input wire       write_busy_o
);
	reg [19:0] busy_cnt_reg;
	reg [7:0]  oe_cnt_reg;
	always @(posedge sys_clk_i)
	begin
		busy_cnt_reg <= write_busy_o ? busy_cnt_reg + 20'h0_0001 : 20'h0_0000;
		oe_cnt_reg <= sda_oe_o ? oe_cnt_reg + 8'h01 : 8'h00;
	end
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	odrain_low_a: assert property (sda_o == 1'b0)
		else $error("data output not low");
	oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 3))
		else $error("data moved outside clock low");
	oe_after_fall_a: assert property ($changed(sda_oe_o) |-> $past(scl_i, 6))
		else $error("data change not after clock fall");
	hold_high_a: assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*4])
		else $error("data moved while clock high");
	busy_nack_a: assert property (write_busy_o |-> !sda_oe_o)
		else $error("line driven while programming");
	busy_len_a: assert property ($fell(write_busy_o) |-> busy_cnt_reg == WR_CYCLES)
		else $error("programming time wrong");
	busy_min_a: assert property ($rose(write_busy_o) |=> write_busy_o [*8])
		else $error("programming ended early");
	oe_run_a: assert property (oe_cnt_reg <= 8'h76)
		else $error("line held past one byte");
endmodule

// ==== sepr_master_model.sv ====
`timescale 1ns/10ps
// ==========================================
// bus master, clock idles high between frames
module sepr_master_model
(
	input  wire sys_clk_i,
	input  wire sda_i,
	output reg  scl_o,
	output reg  sda_oe_o
);
	localparam real Q = 31.25;
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task start;
	begin
		@(negedge sys_clk_i);
		#(Q + 1.0) sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b0;
	end
	endtask
	task stop;
	begin
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b0;
		#Q;
	end
	endtask
	// msb first, ninth bit is ack
	task xfer(input [7:0] d, input a, output [7:0] q, output r);
		integer i;
	begin
		for (i = 8; i >= 0; i = i - 1)
		begin
			#Q sda_oe_o = (i == 0) ? !a : !d[i - 1];
			#Q scl_o = 1'b1;
			#Q r = sda_i;
			if (i > 0)
				q[i - 1] = r;
			#Q scl_o = 1'b0;
		end
	end
	endtask
endmodule

// ==== test_serial_eeprom_read_and_poll.sv ====
`timescale 1ns/10ps
module test_serial_eeprom_read_and_poll;
	localparam [3:0] DEV = 4'h5;
	reg        sys_clk_i = 1'b0;
	reg        resetn_i = 1'b0;
	reg  [1:0] straps = 2'h2;
	wire       scl;
	wire       m_oe;
	wire       sda_o;
	wire       d_oe;
	wire       busy;
	wire       sda = ~(d_oe | m_oe);
	reg  [7:0] mem [0:16383];
	reg  [7:0] lfsr_reg = 8'h38;
	reg  [7:0] q;
	reg        r;
	reg [13:0] a;
	reg [13:0] x;
	integer    fails = 0;
	integer    check_count = 0;
	integer    i;
	always #5 sys_clk_i = ~sys_clk_i;
	sepr_eeprom #(.DEV_TYPE(DEV), .WR_CYCLES(400)) u_sepr_eeprom (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(d_oe), .chip_select_straps_i(straps),
		.write_busy_o(busy));
	sepr_master_model u_sepr_master_model (
		.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
	function [7:0] rnd(input [7:0] l);
		rnd = {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
	endfunction
	task check(input [7:0] seen, input [7:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	end
	endtask
	task summarize;
	begin
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task dev(input [3:0] t, input [1:0] s, input rw);
	begin
		u_sepr_master_model.start;
		u_sepr_master_model.xfer({t, s, 1'b0, rw}, 1'b1, q, r);
	end
	endtask
	task poll;
		integer k;
	begin
		r = 1'b1;
		for (k = 0; k < 60 && r; k = k + 1)
		begin
			dev(DEV, straps, 1'b0);
			u_sepr_master_model.stop;
			if (k == 0)
				check({6'h00, busy, r}, 8'h03);
		end
		if (r)
		begin
			fails = fails + 1;
			summarize;
		end
		check({7'h00, busy}, 8'h00);
	end
	endtask
	task set_addr(input [13:0] v);
	begin
		dev(DEV, straps, 1'b0);
		check({7'h00, r}, 8'h00);
		u_sepr_master_model.xfer({2'h0, v[13:8]}, 1'b1, q, r);
		check({7'h00, r}, 8'h00);
		u_sepr_master_model.xfer(v[7:0], 1'b1, q, r);
		check({7'h00, r}, 8'h00);
		a = v;
	end
	endtask
	task rd(input integer n);
		integer k;
	begin
		dev(DEV, straps, 1'b1);
		check({6'h00, busy, r}, 8'h00);
		for (k = 1; k <= n; k = k + 1)
		begin
			u_sepr_master_model.xfer(8'hFF, k == n, q, r);
			check(q, mem[a]);
			a = a + 14'h0001;
		end
		u_sepr_master_model.stop;
	end
	endtask
	task wr(input [13:0] v, input integer n);
		integer k;
	begin
		set_addr(v);
		for (k = 0; k < n; k = k + 1)
		begin
			lfsr_reg = rnd(lfsr_reg);
			mem[a] = lfsr_reg;
			u_sepr_master_model.xfer(lfsr_reg, 1'b1, q, r);
			check({7'h00, r}, 8'h00);
			a[5:0] = a[5:0] + 6'h01;
		end
		u_sepr_master_model.stop;
		poll;
	end
	endtask
	initial
	begin
		repeat (6) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		wr(14'h3FFE, 2);
		wr(14'h0000, 4);
		set_addr(14'h3FFE);
		rd(5);
		rd(1);
		set_addr(14'h3FFF);
		rd(1);
		rd(1);
		// ==========================================
		// foreign type code or straps
		for (i = 0; i < 4; i = i + 1)
		begin
			dev(i == 0 ? DEV ^ 4'h1 : DEV, straps ^ i[1:0], 1'b1);
			u_sepr_master_model.stop;
			check({7'h00, r}, 8'h01);
		end
		for (i = 0; i < 4; i = i + 1)
		begin
			lfsr_reg = rnd(lfsr_reg);
			x = {lfsr_reg, 6'h05};
			wr(x, 3);
			set_addr(x);
			rd(3);
		end
		summarize;
	end
endmodule
bind sepr_eeprom sepr_eeprom_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
	.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_straps_i(chip_select_straps_i),
	.write_busy_o(write_busy_o));
